// File: pfpwc_pkg.sv
// pfpwc_pkg: constants, op codes and carrier types of the parallel flash controller.
// assumes a 40 MHz system clock and a 128K x 8 flash with page writes on the far side.
package pfpwc_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int T_WE_LOW_NS = 15;        // least strobe low time
	localparam int T_ADDR_HOLD_NS = 50;     // least address hold after strobe
	localparam int T_ACCESS_NS = 150;       // longest read access time
	localparam int T_BYTE_WIN_US = 200;     // longest gap between byte loads
	localparam int T_LOAD_TMO_US = 300;     // device starts programming after this
	localparam int T_PROG_MS = 10;          // longest page program time
	localparam int T_ERASE_MS = 50;         // chip erase time
	localparam int T_ID_PAUSE_US = 10;      // least pause after id commands
	localparam int WE_LOW_CYC = (T_WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int ADDR_HOLD_CYC = (T_ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_CYC = 3;
	localparam int BYTE_WIN_CYC = (T_BYTE_WIN_US * 1000000) / CLK_PERIOD_PS;
	// nanoseconds over the period in nanoseconds, so no product overflows 32 bits
	localparam int PROG_POLL_CYC = ((T_PROG_MS * 1000 + T_LOAD_TMO_US) * 1000)
		/ (CLK_PERIOD_PS / 1000);
	localparam int ERASE_POLL_CYC = (T_ERASE_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int ID_PAUSE_CYC = (T_ID_PAUSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------
	// flash geometry and command codes
	// ----------------------------------------
	localparam int ADDR_W = 17;
	localparam int PAGE_BYTES = 128;
	localparam int IDX_W = 7;
	localparam logic [ADDR_W-1:0] CMD_ADDR_A = 17'h05555;
	localparam logic [ADDR_W-1:0] CMD_ADDR_B = 17'h02aaa;
	localparam logic [ADDR_W-1:0] ID_ADDR_MAKER = 17'h00000;
	localparam logic [7:0] CMD_UNLOCK_1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK_2 = 8'h55;
	localparam logic [7:0] CMD_PAGE = 8'ha0;
	localparam logic [7:0] CMD_SETUP = 8'h80;
	localparam logic [7:0] CMD_ERASE = 8'h10;
	localparam logic [7:0] CMD_ID_ENTER = 8'h60;
	localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;

	// ----------------------------------------
	// software register map and fields
	// ----------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_BUF_DATA = 8'h08;
	localparam logic [7:0] REG_BUF_IDX = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;
	localparam int CMD_START_BIT = 3;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_TMO_BIT = 2;
	localparam int ST_WIN_BIT = 3;
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_PAGE = 3'h1;
	localparam logic [2:0] OP_ERASE = 3'h2;
	localparam logic [2:0] OP_ID_ENTER = 3'h3;
	localparam logic [2:0] OP_ID_EXIT = 3'h4;
	localparam logic [2:0] OP_HW_ID = 3'h5;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] dout;
		logic dout_en;
		logic cs_n;
		logic og_n;
		logic ws_n;
	} pfpwc_pins_t;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} pfpwc_req_t;
endpackage

// File: pfpwc_page_mem.sv
// pfpwc_page_mem: page staging memory, one write port, registered read port.
// assumes writer and reader share clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pfpwc_page_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk_sys,              // system clock
	input wire logic wr_en,                // write strobe
	input wire logic [AW-1:0] wr_addr,     // write index
	input wire logic [WIDTH-1:0] wr_data,  // write byte
	input wire logic [AW-1:0] rd_addr,     // read index
	output logic [WIDTH-1:0] rd_data_ff    // read byte, one cycle later
);
	logic [WIDTH-1:0] mem [DEPTH];

	// ----------------------------------------
	// storage; no reset, contents are loaded by software
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		rd_data_ff <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// File: pfpwc_bus_cycle.sv
// pfpwc_bus_cycle: one read or write cycle on the flash pins.
// assumes the flash data pins are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pfpwc_bus_cycle
	import pfpwc_pkg::*;
(
	input wire logic clk_sys,         // system clock
	input wire logic reset_n,         // synchronous reset, active low
	input wire logic start,           // one-cycle request pulse
	input wire pfpwc_req_t req,       // request, held with start
	input wire logic [7:0] din,       // flash data pins, raw
	output pfpwc_pins_t pins_ff,      // pin drive
	output logic [7:0] rdata_ff,      // captured read byte
	output logic done_ff              // one-cycle completion pulse
);
	typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_ACCESS, C_END} pfpwc_cst_t;
	localparam logic [7:0] STROBE_LAST = 8'(WE_LOW_CYC - 1);
	localparam logic [7:0] HOLD_LAST = 8'(ADDR_HOLD_CYC - 1);
	localparam logic [7:0] ACC_LAST = 8'(ACCESS_CYC + SYNC_CYC);

	pfpwc_cst_t state_ff;
	logic [7:0] cnt_ff;
	logic [7:0] s1_ff, s2_ff, s3_ff, filt_ff;

	// ----------------------------------------
	// data pin synchroniser, counts once stages two and three agree
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		s1_ff <= din;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
		if (!reset_n) begin
			filt_ff <= 8'h00;
		end else if (s2_ff == s3_ff) begin
			filt_ff <= s3_ff;
		end
	end

	// ----------------------------------------
	// cycle sequencer and pin drive
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_ff <= C_IDLE;
			cnt_ff <= 8'h00;
			pins_ff <= '{addr: '0, dout: 8'h00, dout_en: 1'b0, cs_n: 1'b1, og_n: 1'b1, ws_n: 1'b1};
			rdata_ff <= 8'h00;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			cnt_ff <= cnt_ff + 8'h01;
			case (state_ff)
				C_IDLE: begin
					if (start) begin
						pins_ff.addr <= req.addr;
						pins_ff.dout <= req.data;
						pins_ff.dout_en <= req.wr;  // never drive on a read
						pins_ff.cs_n <= 1'b0;       // select with gate high
						pins_ff.og_n <= 1'b1;
						state_ff <= C_SETUP;
					end
				end
				C_SETUP: begin
					cnt_ff <= 8'h00;
					if (pins_ff.dout_en) begin
						pins_ff.ws_n <= 1'b0;       // late fall latches address
						state_ff <= C_STROBE;
					end else begin
						pins_ff.og_n <= 1'b0;       // both low to read
						state_ff <= C_ACCESS;
					end
				end
				C_STROBE: begin
					// longer than the glitch filter so the load counts
					if (cnt_ff == STROBE_LAST) begin
						pins_ff.ws_n <= 1'b1;       // first rise latches data
						cnt_ff <= 8'h00;
						state_ff <= C_HOLD;
					end
				end
				C_HOLD: begin
					if (cnt_ff == HOLD_LAST) begin
						pins_ff.cs_n <= 1'b1;
						state_ff <= C_END;
					end
				end
				C_ACCESS: begin
					// access time plus synchroniser depth before sampling
					if (cnt_ff == ACC_LAST) begin
						rdata_ff <= filt_ff;
						pins_ff.og_n <= 1'b1;
						pins_ff.cs_n <= 1'b1;
						state_ff <= C_END;
					end
				end
				C_END: begin
					pins_ff.dout_en <= 1'b0;
					done_ff <= 1'b1;
					state_ff <= C_IDLE;
				end
				default: begin
					state_ff <= C_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: pfpwc_top.sv
// pfpwc_top: host-side controller for a 128K x 8 page-write parallel flash.
// assumes software on a plain strobe port and the flash wired straight to the pins.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - flash drives data only with both selects low
// - program in whole 128-byte pages always
// - write starts with select, strobe low, gate high
// - byte loads spaced under 200 microseconds
// - upper bits page, low seven bits byte
// - protected writes need unlock command first
// - unlock is AA, 55, A0 writes
// - three-byte exit leaves identification mode
// - erase is six fixed command writes
// - id entry ends with 60, then pause
// - id exit ends with F0, then pause
module pfpwc_top
	import pfpwc_pkg::*;
#(
	parameter int BYTE_WIN_LIM = BYTE_WIN_CYC,
	parameter int PROG_POLL_LIM = PROG_POLL_CYC,
	parameter int ERASE_POLL_LIM = ERASE_POLL_CYC
) (
	input wire logic clk_sys,                // system clock, 40 MHz
	input wire logic reset_n,                // synchronous reset, active low
	input wire logic [7:0] reg_addr,         // register byte address
	input wire logic [31:0] reg_wdata,       // register write data
	input wire logic reg_wr,                 // register write strobe
	input wire logic reg_rd,                 // register read strobe
	output logic [31:0] reg_rdata_ff,        // read data, cycle after strobe
	output logic [ADDR_W-1:0] address_pins,  // flash address
	input wire logic [7:0] data_pins_in,     // flash data, sampled
	output logic [7:0] data_pins_out,        // flash data, driven
	output logic data_pins_oe,               // high while we drive data
	output logic chip_select_n,              // flash select, active low
	output logic output_gate_n,              // flash output gate, active low
	output logic write_strobe_n,             // flash write strobe, active low
	output logic id_hv_en_ff                 // raise id line to high voltage
);
	typedef enum logic [3:0] {
		S_IDLE, S_CMD, S_CMD_WAIT, S_FETCH, S_LOAD, S_LOAD_WAIT,
		S_POLL, S_POLL_WAIT, S_PAUSE, S_READ, S_READ_WAIT
	} pfpwc_st_t;
	localparam int WAIT_W = 24;
	localparam logic [WAIT_W-1:0] PROG_LIM = WAIT_W'(PROG_POLL_LIM);
	localparam logic [WAIT_W-1:0] ERASE_LIM = WAIT_W'(ERASE_POLL_LIM);
	localparam logic [WAIT_W-1:0] WIN_LIM = WAIT_W'(BYTE_WIN_LIM);
	localparam logic [WAIT_W-1:0] PAUSE_LIM = WAIT_W'(ID_PAUSE_CYC);
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(PAGE_BYTES - 1);

	pfpwc_st_t state_ff;
	logic [2:0] op_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [IDX_W-1:0] buf_idx_ff;
	logic [IDX_W-1:0] load_idx_ff;
	logic [2:0] step_ff;
	logic [WAIT_W-1:0] wait_ff;
	logic [WAIT_W-1:0] gap_ff;
	logic [7:0] rdata_ff;
	logic [7:0] poll_exp_ff;
	logic prev_tgl_ff;
	logic poll_first_ff;
	logic done_ff, tmo_ff, win_ff;
	logic cyc_start_ff;
	pfpwc_req_t cyc_req_ff;
	pfpwc_pins_t pins;
	logic [7:0] cyc_rdata;
	logic cyc_done;
	logic [7:0] buf_rdata;
	logic buf_wr;
	logic start_cmd;
	logic clr_done, clr_tmo, clr_win;
	logic set_done, set_tmo, set_win;
	pfpwc_req_t step_req;
	logic [2:0] step_last;
	logic busy;

	// ----------------------------------------
	// command byte table
	// ----------------------------------------
	// only bits fourteen to zero matter to the flash; upper bits stay zero
	function automatic pfpwc_req_t cmd_step(input logic [2:0] op, input logic [2:0] idx);
		pfpwc_req_t r;
		r.wr = 1'b1;
		r.addr = (idx == 3'h1 || idx == 3'h4) ? CMD_ADDR_B : CMD_ADDR_A;
		r.data = (idx == 3'h1 || idx == 3'h4) ? CMD_UNLOCK_2 : CMD_UNLOCK_1;
		if (idx == 3'h2) begin
			case (op)
				OP_PAGE: r.data = CMD_PAGE;
				OP_ID_EXIT: r.data = CMD_ID_EXIT;
				default: r.data = CMD_SETUP;
			endcase
		end else if (idx == 3'h5) begin
			r.data = (op == OP_ERASE) ? CMD_ERASE : CMD_ID_ENTER;
		end
		return r;
	endfunction

	always_comb begin
		step_req = cmd_step(op_ff, step_ff);
		step_last = (op_ff == OP_ERASE || op_ff == OP_ID_ENTER) ? 3'h5 : 3'h2;
	end

	// ----------------------------------------
	// software strobe decode
	// ----------------------------------------
	assign busy = (state_ff != S_IDLE);
	// starts are dropped while busy so no command overlaps a running sequence
	assign start_cmd = reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_START_BIT] && !busy;
	assign buf_wr = reg_wr && reg_addr == REG_BUF_DATA;
	assign clr_done = reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_DONE_BIT];
	assign clr_tmo = reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_TMO_BIT];
	assign clr_win = reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_WIN_BIT];

	pfpwc_page_mem #(
		.WIDTH(8),
		.DEPTH(PAGE_BYTES),
		.AW(IDX_W)
	) u_mem (
		.clk_sys(clk_sys),
		.wr_en(buf_wr),
		.wr_addr(buf_idx_ff),
		.wr_data(reg_wdata[7:0]),
		.rd_addr(load_idx_ff),
		.rd_data_ff(buf_rdata)
	);

	pfpwc_bus_cycle u_cyc (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.start(cyc_start_ff),
		.req(cyc_req_ff),
		.din(data_pins_in),
		.pins_ff(pins),
		.rdata_ff(cyc_rdata),
		.done_ff(cyc_done)
	);

	// pin outputs come from the cycle engine's own registers
	assign address_pins = pins.addr;
	assign data_pins_out = pins.dout;
	assign data_pins_oe = pins.dout_en;
	assign chip_select_n = pins.cs_n;
	assign output_gate_n = pins.og_n;
	assign write_strobe_n = pins.ws_n;

	// ----------------------------------------
	// software registers: op, address, buffer index
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			op_ff <= OP_READ;
			addr_ff <= '0;
			buf_idx_ff <= '0;
		end else begin
			if (start_cmd) begin
				op_ff <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == REG_ADDR && !busy) begin
				addr_ff <= reg_wdata[ADDR_W-1:0];
			end
			if (reg_wr && reg_addr == REG_BUF_IDX) begin
				buf_idx_ff <= reg_wdata[IDX_W-1:0];
			end else if (buf_wr) begin
				buf_idx_ff <= buf_idx_ff + 1'b1;  // auto-increment for streaming a page
			end
		end
	end

	// ----------------------------------------
	// main sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_ff <= S_IDLE;
			step_ff <= 3'h0;
			load_idx_ff <= '0;
			wait_ff <= '0;
			cyc_start_ff <= 1'b0;
			cyc_req_ff <= '0;
			rdata_ff <= 8'h00;
			poll_exp_ff <= 8'h00;
			prev_tgl_ff <= 1'b0;
			poll_first_ff <= 1'b1;
			id_hv_en_ff <= 1'b0;
			set_done <= 1'b0;
			set_tmo <= 1'b0;
		end else begin
			cyc_start_ff <= 1'b0;
			set_done <= 1'b0;
			set_tmo <= 1'b0;
			wait_ff <= wait_ff + 1'b1;
			case (state_ff)
				S_IDLE: begin
					step_ff <= 3'h0;
					load_idx_ff <= '0;
					poll_first_ff <= 1'b1;
					wait_ff <= '0;
					if (start_cmd) begin
						if (reg_wdata[2:0] == OP_READ || reg_wdata[2:0] == OP_HW_ID) begin
							state_ff <= S_READ;
						end else begin
							state_ff <= S_CMD;
						end
						id_hv_en_ff <= (reg_wdata[2:0] == OP_HW_ID);
					end
				end
				S_CMD: begin
					// every page is preceded by the unlock
					// bytes go out exactly in table order so no sequence aborts
					cyc_req_ff <= step_req;
					cyc_start_ff <= 1'b1;
					state_ff <= S_CMD_WAIT;
				end
				S_CMD_WAIT: begin
					wait_ff <= '0;
					if (cyc_done) begin
						step_ff <= step_ff + 3'h1;
						if (step_ff != step_last) begin
							state_ff <= S_CMD;
						end else if (op_ff == OP_PAGE) begin
							state_ff <= S_FETCH;
						end else if (op_ff == OP_ERASE) begin
							poll_exp_ff <= ERASED_BYTE;
							state_ff <= S_POLL;  // erase is polled like a page, expecting FF
						end else begin
							state_ff <= S_PAUSE;
						end
					end
				end
				S_FETCH: begin
					// staging memory read data is valid one cycle after the index
					state_ff <= S_LOAD;
				end
				S_LOAD: begin
					cyc_req_ff.wr <= 1'b1;
					cyc_req_ff.addr <= {addr_ff[ADDR_W-1:IDX_W], load_idx_ff};
					cyc_req_ff.data <= buf_rdata;
					poll_exp_ff <= buf_rdata;
					cyc_start_ff <= 1'b1;
					state_ff <= S_LOAD_WAIT;
				end
				S_LOAD_WAIT: begin
					wait_ff <= '0;
					if (cyc_done) begin
						if (load_idx_ff == IDX_LAST) begin
							state_ff <= S_POLL;  // all 128 bytes always sent
						end else begin
							load_idx_ff <= load_idx_ff + 1'b1;  // ascending order
							state_ff <= S_FETCH;
						end
					end
				end
				S_POLL: begin
					// read back the last loaded byte, or CMD_ADDR_A on erase; load silence lets programming start
					cyc_req_ff.wr <= 1'b0;
					cyc_req_ff.addr <= (op_ff == OP_PAGE) ? cyc_req_ff.addr : CMD_ADDR_A;
					cyc_start_ff <= 1'b1;
					state_ff <= S_POLL_WAIT;
				end
				S_POLL_WAIT: begin
					if (cyc_done) begin
						rdata_ff <= cyc_rdata;
						prev_tgl_ff <= cyc_rdata[TOGGLE_BIT];
						poll_first_ff <= 1'b0;
						// finished once the toggle stops and the polled bit matches bit 7 of the expected byte
						if (!poll_first_ff && cyc_rdata[TOGGLE_BIT] == prev_tgl_ff &&
							cyc_rdata[POLL_BIT] == poll_exp_ff[POLL_BIT]) begin
							set_done <= 1'b1;
							state_ff <= S_IDLE;
						end else if (wait_ff >= ((op_ff == OP_ERASE) ? ERASE_LIM : PROG_LIM)) begin
							set_tmo <= 1'b1;
							state_ff <= S_IDLE;
						end else begin
							state_ff <= S_POLL;
						end
					end
				end
				S_PAUSE: begin
					if (wait_ff >= PAUSE_LIM) begin
						set_done <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
				S_READ: begin
					// in id mode address zero and one give the identity codes
					cyc_req_ff.wr <= 1'b0;
					cyc_req_ff.addr <= addr_ff;
					cyc_start_ff <= 1'b1;
					state_ff <= S_READ_WAIT;
				end
				S_READ_WAIT: begin
					if (cyc_done) begin
						rdata_ff <= cyc_rdata;
						id_hv_en_ff <= 1'b0;
						set_done <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
				default: begin
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// byte-load spacing watch
	// ----------------------------------------
	// loads here are about ten cycles (250 ns) apart; this only flags a stalled page
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			gap_ff <= '0;
			set_win <= 1'b0;
		end else begin
			set_win <= 1'b0;
			if (state_ff != S_FETCH && state_ff != S_LOAD && state_ff != S_LOAD_WAIT) begin
				gap_ff <= '0;
			end else if (cyc_done) begin
				gap_ff <= '0;
			end else begin
				gap_ff <= gap_ff + 1'b1;
				set_win <= (gap_ff == WIN_LIM);
			end
		end
	end

	// ----------------------------------------
	// sticky status, set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			done_ff <= 1'b0;
			tmo_ff <= 1'b0;
			win_ff <= 1'b0;
		end else begin
			done_ff <= set_done | (done_ff & ~clr_done);
			tmo_ff <= set_tmo | (tmo_ff & ~clr_tmo);
			win_ff <= set_win | (win_ff & ~clr_win);
		end
	end

	// ----------------------------------------
	// register read port, data one cycle after strobe
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			reg_rdata_ff <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CMD: reg_rdata_ff <= {29'h0, op_ff};
				REG_ADDR: reg_rdata_ff <= {15'h0, addr_ff};
				REG_BUF_IDX: reg_rdata_ff <= {25'h0, buf_idx_ff};
				REG_STATUS: reg_rdata_ff <= {28'h0, win_ff, tmo_ff, done_ff, busy};
				REG_RDATA: reg_rdata_ff <= {24'h0, rdata_ff};
				default: reg_rdata_ff <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_ff <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// File: pfpwc_top_props.sv
// pfpwc_top_props: flash pin order checks.
// assumes a bind into pfpwc_top.
`timescale 1ns/1ps
`default_nettype none
module pfpwc_top_props (
	input wire logic clk_sys, // clock
	input wire logic reset_n, // reset
	input wire logic [16:0] address_pins, // addr
	input wire logic [7:0] data_pins_out, // data
	input wire logic data_pins_oe, // drive
	input wire logic chip_select_n, // select
	input wire logic output_gate_n, // gate
	input wire logic write_strobe_n, // strobe
	input wire logic id_hv_en_ff // id volts
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// strobe only in a selected, driven, ungated cycle
	AST_ENTRY: assert property ($fell(write_strobe_n) |-> !chip_select_n)
		else $error("strobe unselected");
	AST_INHIBIT: assert property (!write_strobe_n |-> output_gate_n && data_pins_oe)
		else $error("strobe with gate");
	AST_READ: assert property (!output_gate_n |-> !chip_select_n && !data_pins_oe)
		else $error("bad read");
	// two low cycles so the glitch filter never eats it
	AST_WIDTH: assert property ($fell(write_strobe_n) |=> !write_strobe_n)
		else $error("short strobe");
	AST_LATCH: assert property (!write_strobe_n |=> $stable({address_pins, data_pins_out}))
		else $error("bus moved");
	AST_HOLD: assert property ($rose(write_strobe_n) |->
		(!chip_select_n && $stable(address_pins))[*2]) else $error("short hold");
	AST_DESEL: assert property (chip_select_n |-> write_strobe_n && output_gate_n)
		else $error("strobe deselected");
	AST_HV: assert property (id_hv_en_ff |-> write_strobe_n)
		else $error("write at id volts");
endmodule
bind pfpwc_top pfpwc_top_props u_props (.clk_sys(clk_sys), .reset_n(reset_n),
	.address_pins(address_pins), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
	.chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
	.write_strobe_n(write_strobe_n), .id_hv_en_ff(id_hv_en_ff));
`default_nettype wire

// File: pfpwc_flash_model.sv
// pfpwc_flash_model: behavioural page-write flash.
// assumes the bench resolves the data wire.
`timescale 1ns/1ps
`default_nettype none
module pfpwc_flash_model #(
	parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary
	parameter logic [7:0] PART_ID = 8'h7e, // arbitrary
	parameter int TMO_NS = 5000, // short load timeout
	parameter int PROG_NS = 20000 // short busy time
) (
	input wire logic [16:0] a, // address
	input wire logic [7:0] d, // data in
	input wire logic cs_n, // select
	input wire logic og_n, // gate
	input wire logic ws_n, // strobe
	input wire logic hv, // id volts
	output logic [7:0] q, // data out
	output logic q_en // drives q
);
	localparam logic [45:0] UL = {15'h5555, 8'haa, 15'h2aaa, 8'h55};
	logic [7:0] mem [0:131071];
	logic [7:0] pb [0:127];
	logic [137:0] h = '0;
	logic [16:0] la;
	logic [9:0] pg;
	logic [7:0] last = 8'hff;
	logic ld = 0, bsy = 0, idm = 0, tg = 0;
	realtime tf, tl, td;
	initial foreach (mem[i]) mem[i] = 8'hff;
	// status bits replace data while a write cycle runs
	assign q_en = !cs_n && !og_n;
	assign q = idm || hv ? (a[0] ? PART_ID : MAKER_ID) :
		ld || bsy ? {~last[7], tg, last[5:0]} : mem[a];
	always @(negedge og_n) if (!cs_n && (ld || bsy)) tg = !tg;
	// commands slide through a six-byte history, so a wrong byte drops out
	task automatic take(input logic [16:0] ad, input logic [7:0] dv);
		if (ld) begin
			pb[ad[6:0]] = dv;
			pg = ad[16:7];
			last = dv;
			tl = $realtime;
		end else begin
			h = {h[114:0], ad[14:0], dv};
			if (h[68:0] == {UL, 15'h5555, 8'ha0}) begin
				ld = 1;
				tl = $realtime;
				foreach (pb[i]) pb[i] = 8'hff;
			end
			if (h == {UL, 15'h5555, 8'h80, UL, 15'h5555, 8'h10}) begin
				bsy = 1;
				last = 8'hff;
				td = $realtime + PROG_NS;
				foreach (mem[i]) mem[i] = 8'hff;
				foreach (pb[i]) pb[i] = 8'hff;
			end
			if (h == {UL, 15'h5555, 8'h80, UL, 15'h5555, 8'h60}) idm = 1;
			if (h[68:0] == {UL, 15'h5555, 8'hf0}) idm = 0;
		end
	endtask
	// address at strobe fall, data at rise
	always @(negedge ws_n) begin
		tf = $realtime;
		la = a;
	end
	always @(posedge ws_n)
		if (!cs_n && og_n && !bsy && $realtime - tf >= 15) take(la, d);
	// load timeout, then self-timed completion
	always #100 begin
		if (ld && $realtime - tl > TMO_NS) begin
			ld = 0;
			bsy = 1;
			td = $realtime + PROG_NS;
		end
		if (bsy && $realtime >= td) begin
			foreach (pb[i]) mem[{pg, 7'(i)}] = pb[i];
			bsy = 0;
		end
	end
endmodule
`default_nettype wire

// File: tb_parallel_flash_page_write_control.sv
// tb_parallel_flash_page_write_control: self-checking bench.
// assumes pfpwc_flash_model on the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_flash_page_write_control;
	import pfpwc_pkg::*;
	localparam logic [7:0] IDM = 8'h3c; // arbitrary
	localparam logic [7:0] IDP = 8'h7e; // arbitrary
	typedef struct packed {logic [16:0] pa; logic [7:0] b; logic [6:0] x;} pfpwc_row_t;
	pfpwc_row_t rows [3] = '{'{17'h0, 8'h10, 7'h5}, '{17'h1ff80, 8'hc3, 7'h7f},
		'{17'h5500, 8'h80, 7'h0}};
	logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, oe, cs_n, og_n, ws_n, hv, qe;
	logic [7:0] reg_addr = 0, dout, q, dq;
	logic [31:0] reg_wdata = 0, rdat, rv;
	logic [16:0] ap;
	int n_mismatch = 0, n_tests = 0;
	// a released wire shows a moving pattern
	assign dq = oe ? dout : qe ? q : {8{clk_sys}} ^ 8'h5a;
	pfpwc_top #(.BYTE_WIN_LIM(100), .PROG_POLL_LIM(20000), .ERASE_POLL_LIM(20000)) dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdat), .address_pins(ap),
		.data_pins_in(dq), .data_pins_out(dout), .data_pins_oe(oe), .chip_select_n(cs_n),
		.output_gate_n(og_n), .write_strobe_n(ws_n), .id_hv_en_ff(hv));
	pfpwc_flash_model #(.MAKER_ID(IDM), .PART_ID(IDP)) fl (.a(ap), .d(dout), .cs_n(cs_n),
		.og_n(og_n), .ws_n(ws_n), .hv(hv), .q(q), .q_en(qe));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic complete_run;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	// one register cycle; read data sampled in the cycle after the strobe
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= ad;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 0;
		reg_rd <= 0;
		#1 rv = rdat;
	endtask
	// done is sticky, so a late busy cannot end the wait early
	task automatic op(input logic [2:0] o, input logic [16:0] ad);
		int k = 0;
		bus(1, REG_ADDR, 32'(ad));
		bus(1, REG_CMD, 32'(o) | 32'h8);
		do begin
			bus(0, REG_STATUS, 0);
			k++;
		end while (rv[2:1] === 2'b00 && k < 30000);
		chk("status", rv, 32'h2);
		bus(1, REG_STATUS, 32'he);
	endtask
	task automatic look(input string nm, input logic [2:0] o, input logic [16:0] ad,
		input logic [7:0] e);
		op(o, ad);
		bus(0, REG_RDATA, 0);
		chk(nm, rv, 32'(e));
	endtask
	// watchdog well past the expected run
	initial begin
		#2500000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1;
		foreach (rows[r]) begin
			bus(1, REG_BUF_IDX, 0);
			for (int i = 0; i < PAGE_BYTES; i++)
				bus(1, REG_BUF_DATA, 32'(8'(rows[r].b + i)));
			op(OP_PAGE, rows[r].pa);
			look("page", OP_READ, rows[r].pa | 17'(rows[r].x),
				8'(rows[r].b + rows[r].x));
		end
		bus(0, 8'hfc, 0);
		chk("unmapped", rv, 0);
		op(OP_ERASE, 0);
		look("erased", OP_READ, 17'h5505, 8'hff);
		op(OP_ID_ENTER, 0);
		look("maker", OP_READ, 0, IDM);
		look("part", OP_READ, 1, IDP);
		op(OP_ID_EXIT, 0);
		look("normal", OP_READ, 1, 8'hff);
		look("hw id", OP_HW_ID, 1, IDP);
		bus(0, REG_ADDR, 0);
		chk("addr", rv, 32'h1);
		// reset in mid-command parks the pins and drops the sequence
		bus(1, REG_CMD, 32'(OP_ERASE) | 32'h8);
		repeat (4) @(posedge clk_sys);
		#1 chk("selected", cs_n, 0);
		@(posedge clk_sys) reset_n <= 0;
		repeat (3) @(posedge clk_sys);
		#1 chk("idle", {cs_n, og_n, ws_n, oe, hv}, 5'h1c);
		@(posedge clk_sys) reset_n <= 1;
		bus(0, REG_STATUS, 0);
		chk("reset status", rv, 0);
		bus(0, REG_ADDR, 0);
		chk("reset addr", rv, 0);
		complete_run();
	end
endmodule
`default_nettype wire
